/* File: rtl/serial_eeprom_bus_slave.sv */
// Two-wire serial EEPROM slave: sequence control and programming engine
//
// Overview of operation
// - SDA edges during SCL high: start, stop
// - Change SDA only while SCL is low
// - Acknowledge matched byte from eighth fall onward
// - Release SDA in ninth clock when reading
// - Three bytes, each followed by acknowledge
// - Only stop after 27th clock starts programming
// - Answer only when select bit equals pin
// - Upper address bits come from write select
// - Write select aborts running programming
// - Read select ignored while programming
// - Random read: select, address, restart, read
// - Load byte in ack clock, drive after
// - One bit per clock, increment on ack
// - Address counter never wraps to zero
// - Stop releases output, returns to idle
// - Erase to ones, then write the zeros
// - Self-timed cycle, typical ten milliseconds
// - Skip write if no zeros, skip erase if erased
// - Output released after power-up
// - Stop resets control, except programming stop
// - Bulk pin at stop, after FF written to address 0, erases whole array
// - No acknowledge while programming means busy
// - Select word layout and direction bit
`timescale 1ns/1ns
module serial_eeprom_bus_slave #(
    parameter int PROG_PHASE_CYC = eeprom_slave_pkg::PROG_PHASE_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic device_select_input,
    input wire logic bulk_erase_input,
    output logic prog_busy
);
    import eeprom_slave_pkg::*;

    // ==========================================================
    // State record
    // ==========================================================
    typedef struct packed {
        logic scl_q;
        logic sda_q;
        bus_state_t bus_q;
        logic [CNT_W-1:0] cnt_q;
        logic [7:0] shift_q;
        logic drive_q;
        logic [1:0] upper_q;
        logic [ADDR_W-1:0] addr_q;
        logic [7:0] data_q;
        prog_state_t prog_q;
        logic bulk_q;
        logic [TIMER_W-1:0] timer_q;
        logic [MEM_WORDS-1:0][7:0] mem_q;
    } slave_t;

    slave_t st;
    slave_t n;
    line_sample_if ls ();

    localparam logic [TIMER_W-1:0] PHASE_LOAD =
        TIMER_W'(PROG_PHASE_CYC - 1);

    // ==========================================================
    // Line synchronisation
    // ==========================================================
    line_sampler u_sampler (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .cs_i(device_select_input),
        .bulk_i(bulk_erase_input),
        .ls(ls)
    );

    // Edge and condition detection on synchronised samples
    logic rise_ev;
    logic fall_ev;
    logic start_ev;
    logic stop_ev;
    logic busy;
    logic sel_match;
    logic [ADDR_W-1:0] next_addr;

    assign rise_ev = ls.scl & ~st.scl_q;
    assign fall_ev = ~ls.scl & st.scl_q;
    assign start_ev = st.scl_q & ls.scl & st.sda_q & ~ls.sda;
    assign stop_ev = st.scl_q & ls.scl & ~st.sda_q & ls.sda;
    assign busy = (st.prog_q != P_IDLE);
    // Prefix and chip-select bit must both agree
    assign sel_match = (st.shift_q[7:4] == SELECT_PREFIX) &&
        (st.shift_q[SEL_CS_BIT] == ls.cs);
    // Saturate at the top word rather than rolling over
    assign next_addr = (st.addr_q == ADDR_MAX) ? ADDR_MAX :
        st.addr_q + 10'h001;

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        n = st;
        n.scl_q = ls.scl;
        n.sda_q = ls.sda;

        // Programming engine, one timer per phase
        case (st.prog_q)
            P_IDLE: begin
                n.timer_q = st.timer_q;
            end
            P_ERASE: begin
                if (st.timer_q == '0) begin
                    if (st.bulk_q) begin
                        n.mem_q = '1;
                        n.prog_q = P_IDLE;
                    end else begin
                        n.mem_q[st.addr_q] = ERASED_BYTE;
                        if (st.data_q == ERASED_BYTE) begin
                            n.prog_q = P_IDLE;
                        end else begin
                            n.prog_q = P_WRITE;
                            n.timer_q = PHASE_LOAD;
                        end
                    end
                end else begin
                    n.timer_q = st.timer_q - 21'h00_0001;
                end
            end
            P_WRITE: begin
                if (st.timer_q == '0) begin
                    // Only zero bits of the data register clear cells
                    n.mem_q[st.addr_q] =
                        st.mem_q[st.addr_q] & st.data_q;
                    n.prog_q = P_IDLE;
                end else begin
                    n.timer_q = st.timer_q - 21'h00_0001;
                end
            end
            default: begin
                n.prog_q = P_IDLE;
            end
        endcase

        // Bus sequence control
        if (start_ev) begin
            // Repeated start lands here too, keeping the address
            n.bus_q = B_SELECT;
            n.cnt_q = '0;
            n.drive_q = 1'b0;
        end else if (stop_ev) begin
            // Three bytes done; the stop's own SCL rise counted one clock
            if (st.bus_q == B_ARMED && st.cnt_q <= 4'h1 && !busy) begin
                n.bulk_q = ls.bulk && (st.addr_q == ADDR_ZERO) &&
                    (st.data_q == ERASED_BYTE);
                n.timer_q = PHASE_LOAD;
                if (n.bulk_q) begin
                    n.prog_q = P_ERASE;
                end else if (st.mem_q[st.addr_q] != ERASED_BYTE) begin
                    n.prog_q = P_ERASE;
                end else if (st.data_q != ERASED_BYTE) begin
                    n.prog_q = P_WRITE;
                end else begin
                    n.prog_q = P_IDLE;
                end
            end
            // Address and data survive so programming can proceed
            n.bus_q = B_IDLE;
            n.drive_q = 1'b0;
            n.cnt_q = '0;
        end else if (rise_ev && st.bus_q != B_IDLE) begin
            // Sample on the rising edge, valid while SCL is high
            if (st.cnt_q < DATA_BITS) begin
                if (st.bus_q != B_READ) begin
                    n.shift_q = {st.shift_q[6:0], ls.sda};
                end
            end else if (st.bus_q == B_READ_ACK) begin
                n.shift_q = st.mem_q[st.addr_q];
            end else if (st.bus_q == B_READ) begin
                if (!ls.sda) begin
                    // Master acknowledge: fetch the following word
                    n.addr_q = next_addr;
                    n.shift_q = st.mem_q[next_addr];
                end else begin
                    n.bus_q = B_IGNORE;
                end
            end
            n.cnt_q = st.cnt_q + 4'h1;
        end else if (fall_ev && st.bus_q != B_IDLE) begin
            // Changes of SDA happen only after SCL has gone low
            if (st.cnt_q == DATA_BITS) begin
                case (st.bus_q)
                    B_SELECT: begin
                        if (!sel_match) begin
                            n.bus_q = B_IGNORE;
                        end else if (!st.shift_q[SEL_DIR_BIT]) begin
                            n.upper_q = {st.shift_q[SEL_TOP_BIT],
                                st.shift_q[SEL_UPPER_BIT]};
                            n.drive_q = 1'b1;
                            n.bus_q = B_ADDRESS;
                            n.prog_q = P_IDLE;
                        end else if (busy) begin
                            // Silence tells a polling master to wait
                            n.bus_q = B_IGNORE;
                        end else begin
                            n.drive_q = 1'b1;
                            n.bus_q = B_READ_ACK;
                        end
                    end
                    B_ADDRESS: begin
                        n.addr_q = {st.upper_q, st.shift_q};
                        n.drive_q = 1'b1;
                        n.bus_q = B_DATA;
                    end
                    B_DATA: begin
                        n.data_q = st.shift_q;
                        n.drive_q = 1'b1;
                        n.bus_q = B_ARMED;
                    end
                    B_ARMED: begin
                        // A fourth byte cancels the armed program
                        n.bus_q = B_IGNORE;
                    end
                    B_READ: begin
                        n.drive_q = 1'b0;
                    end
                    default: begin
                        n.drive_q = 1'b0;
                    end
                endcase
            end else if (st.cnt_q == ACK_CLOCK) begin
                n.cnt_q = '0;
                if (st.bus_q == B_READ || st.bus_q == B_READ_ACK) begin
                    n.bus_q = B_READ;
                    n.drive_q = ~st.shift_q[7];
                end else begin
                    n.drive_q = 1'b0;
                end
            end else if (st.bus_q == B_READ && st.cnt_q != '0) begin
                // Present the next bit of the outgoing byte
                n.shift_q = {st.shift_q[6:0], 1'b0};
                n.drive_q = ~st.shift_q[6];
            end
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Array reset to erased only stands in for nonvolatile content
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st <= '0;
            st.scl_q <= 1'b1;
            st.sda_q <= 1'b1;
            st.mem_q <= '1;
        end else begin
            st <= n;
        end
    end

    // Open drain: only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe = st.drive_q;
    assign prog_busy = busy;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    start_enters_select_a: assert property (
        start_ev |=> (st.bus_q == B_SELECT) && !st.drive_q)
        else $error("start did not enter select phase");

    drive_scl_low_a: assert property (
        $rose(st.drive_q) |-> !st.scl_q)
        else $error("SDA pulled low while SCL high");

    address_ack_a: assert property (
        fall_ev && st.cnt_q == DATA_BITS && st.bus_q == B_ADDRESS
        |=> st.drive_q && st.bus_q == B_DATA)
        else $error("address byte not acknowledged");

    read_release_a: assert property (
        fall_ev && st.cnt_q == DATA_BITS && st.bus_q == B_READ
        |=> !st.drive_q)
        else $error("SDA not released for master acknowledge");

    prog_by_stop_a: assert property (
        $rose(busy) |-> $past(stop_ev) && $past(st.bus_q) == B_ARMED)
        else $error("programming started without armed stop");

    write_abort_a: assert property (
        busy && fall_ev && st.bus_q == B_SELECT &&
        st.cnt_q == DATA_BITS && sel_match && !st.shift_q[SEL_DIR_BIT]
        |=> !busy)
        else $error("write select did not abort programming");

    poll_silent_a: assert property (
        busy && fall_ev && st.bus_q == B_SELECT &&
        st.cnt_q == DATA_BITS && st.shift_q[SEL_DIR_BIT]
        |=> !st.drive_q [*2])
        else $error("read select acknowledged while programming");

    addr_saturate_a: assert property (
        st.bus_q == B_READ && st.addr_q == ADDR_MAX
        |=> st.addr_q == ADDR_MAX)
        else $error("address counter rolled over");

    stop_idle_a: assert property (
        stop_ev |=> !sda_oe && st.bus_q == B_IDLE)
        else $error("stop did not release output and idle");

    phase_length_a: assert property (
        $rose(busy) |-> (st.timer_q == PHASE_LOAD))
        else $error("programming timer loaded wrongly");

endmodule : serial_eeprom_bus_slave

/* File: rtl/eeprom_slave_pkg.sv */
// Shared constants and state types of the serial EEPROM bus slave
package eeprom_slave_pkg;

    // ==========================================================
    // Clock and programming time
    // ==========================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TYP_MS = 10;
    localparam int PROG_MAX_MS = 20;
    localparam int NS_PER_MS = 1_000_000;
    // Erase and write phases share the typical cycle half and half
    localparam int PROG_PHASE_CYC_DEF =
        (PROG_TYP_MS * NS_PER_MS / CLK_PERIOD_NS) / 2;
    localparam int PROG_MAX_CYC = PROG_MAX_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int TIMER_W = 21;

    // ==========================================================
    // Memory organisation
    // ==========================================================
    localparam int MEM_WORDS = 1024;
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] ADDR_MAX = 10'h3FF;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 10'h000;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // ==========================================================
    // Select word layout
    // ==========================================================
    localparam logic [3:0] SELECT_PREFIX = 4'hA;
    localparam int SEL_TOP_BIT = 3;
    localparam int SEL_UPPER_BIT = 2;
    localparam int SEL_CS_BIT = 1;
    localparam int SEL_DIR_BIT = 0;

    // ==========================================================
    // Bit counting within a byte
    // ==========================================================
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] DATA_BITS = 4'h8;
    localparam logic [CNT_W-1:0] ACK_CLOCK = 4'h9;

    // ==========================================================
    // Sequence control and programming engine states
    // ==========================================================
    typedef enum logic [2:0] {
        B_IDLE,
        B_SELECT,
        B_ADDRESS,
        B_DATA,
        B_ARMED,
        B_READ_ACK,
        B_READ,
        B_IGNORE
    } bus_state_t;

    typedef enum logic [1:0] {
        P_IDLE,
        P_ERASE,
        P_WRITE
    } prog_state_t;

endpackage : eeprom_slave_pkg

/* File: rtl/line_sample_if.sv */
// Synchronised bus and pin levels passed from the sampler to the slave
`timescale 1ns/1ns
interface line_sample_if;
    logic scl;
    logic sda;
    logic cs;
    logic bulk;

    modport source (output scl, output sda, output cs, output bulk);
    modport sink (input scl, input sda, input cs, input bulk);
endinterface : line_sample_if

/* File: rtl/line_sampler.sv */
// Two-flop synchroniser for the bus lines and the strap pins
`timescale 1ns/1ns
module line_sampler (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic cs_i,
    input wire logic bulk_i,
    line_sample_if.source ls
);
    import eeprom_slave_pkg::*;

    typedef struct packed {
        logic [3:0] meta;
        logic [3:0] sync;
    } sampler_t;

    sampler_t st;
    sampler_t n;

    // ==========================================================
    // Synchroniser chain
    // ==========================================================
    // First stage feeds only the second stage
    always_comb begin
        n = st;
        n.meta = {bulk_i, cs_i, sda_i, scl_i};
        n.sync = st.meta;
    end

    // Lines reset high and pins low: no false start, no stray select
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st <= {4'h3, 4'h3};
        end else begin
            st <= n;
        end
    end

    // Outputs taken from the second stage only
    assign ls.scl = st.sync[0];
    assign ls.sda = st.sync[1];
    assign ls.cs = st.sync[2];
    assign ls.bulk = st.sync[3];
endmodule : line_sampler

/* File: verif/bus_master_model.sv */
// Behavioural two-wire bus master that drives the slave's clock and data
`timescale 1ns/1ns
module bus_master_model (
    input wire logic link_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // ==========================================================
    // Line control
    // ==========================================================
    // Idle bus: clock parked high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // A third of a bit; the clock stands still between frames
    task automatic q_wait();
        repeat (2) @(posedge link_clk);
    endtask : q_wait

    // Data falls while clock is high; also serves as repeated start
    task automatic start_cond();
        sda_low <= 1'b0;
        q_wait();
        scl <= 1'b1;
        q_wait();
        sda_low <= 1'b1;
        q_wait();
        scl <= 1'b0;
        q_wait();
    endtask : start_cond

    // Data rises while clock is high; bus left idle
    task automatic stop_cond();
        sda_low <= 1'b1;
        q_wait();
        scl <= 1'b1;
        q_wait();
        sda_low <= 1'b0;
        q_wait();
    endtask : stop_cond

    // Data moves only with clock low, sampled late in the high phase
    task automatic put_bit(input logic b, output logic s);
        sda_low <= !b;
        q_wait();
        scl <= 1'b1;
        q_wait();
        s = sda;
        scl <= 1'b0;
        q_wait();
    endtask : put_bit

    // Eight data clocks then the slave's acknowledge clock
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
        end
        put_bit(1'b1, ack);
    endtask : write_byte

    // Eight clocks to take the byte, then our own acknowledge
    task automatic read_byte(input logic nack, output logic [7:0] d,
                             output logic ack);
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, d[i]);
        end
        put_bit(nack, ack);
    endtask : read_byte
endmodule : bus_master_model

/* File: verif/testbench.sv */
// Self-checking bench for the serial EEPROM bus slave
`timescale 1ns/1ns
module testbench;
    import eeprom_slave_pkg::*;
    // Short phases keep the run small; polls still catch it busy
    localparam int PHASE = 1000;
    logic clk_sys;
    logic link_clk;
    logic sys_rst;
    logic device_select_input;
    logic bulk_erase_input;
    logic sda_o;
    logic sda_oe;
    logic prog_busy;
    logic scl;
    logic m_low;
    logic sda_line;
    int err_total;
    int check_count;
    logic [7:0] exp_mem [MEM_WORDS];
    // Address, data, programming expected to run
    logic [18:0] rows [5] = '{{10'h000, 8'h5A, 1'b1},
        {10'h1FF, 8'hA5, 1'b1}, {10'h2C3, 8'h00, 1'b1},
        {10'h3FE, 8'hFF, 1'b0}, {10'h000, 8'hC3, 1'b1}};

    // Open-drain wire with pull-up
    assign sda_line = !((sda_oe && !sda_o) || m_low);

    serial_eeprom_bus_slave #(.PROG_PHASE_CYC(PHASE)) uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .device_select_input(device_select_input),
        .bulk_erase_input(bulk_erase_input), .prog_busy(prog_busy));

    bus_master_model m (.link_clk(link_clk), .sda(sda_line), .scl(scl),
        .sda_low(m_low));

    // ==========================================================
    // Clocks and helpers
    // ==========================================================
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Link clock with an unrelated phase
    initial begin
        link_clk = 1'b0;
        #13;
        forever #32 link_clk = ~link_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    function automatic logic [7:0] sel(input logic cs, input logic [1:0] hi,
                                       input logic dir);
        return {SELECT_PREFIX, hi, cs, dir};
    endfunction : sel

    // Select, address and data, each acknowledged, then stop
    task automatic prog(input logic [9:0] addr, input logic [7:0] data,
                        input logic bulk);
        logic a;
        logic [23:0] w;
        w = {sel(1'b0, addr[9:8], 1'b0), addr[7:0], data};
        m.start_cond();
        for (int k = 2; k >= 0; k--) begin
            m.write_byte(w[k*8 +: 8], a);
            check({7'h00, a}, 8'h00);
        end
        if (bulk) begin
            @(posedge clk_sys);
            bulk_erase_input <= 1'b1;
        end
        m.stop_cond();
        exp_mem[addr] = data;
    endtask : prog

    // Completion polling; a refused read select means still busy
    task automatic poll(output int busy_n);
        logic a;
        logic [7:0] d;
        logic done;
        busy_n = 0;
        done = 1'b0;
        for (int t = 0; t < 40 && !done; t++) begin
            m.start_cond();
            m.write_byte(sel(1'b0, 2'h0, 1'b1), a);
            if (a === 1'b0) begin
                m.read_byte(1'b1, d, a);
                done = 1'b1;
            end else begin
                busy_n++;
            end
            m.stop_cond();
        end
        check({7'h00, done}, 8'h01);
    endtask : poll

    // Random read of n bytes; the counter must saturate at the top
    task automatic read_seq(input logic [9:0] addr, input int n);
        logic a;
        logic [7:0] d;
        logic [9:0] p;
        m.start_cond();
        m.write_byte(sel(1'b0, addr[9:8], 1'b0), a);
        m.write_byte(addr[7:0], a);
        m.start_cond();
        m.write_byte(sel(1'b0, 2'h0, 1'b1), a);
        check({7'h00, a}, 8'h00);
        p = addr;
        for (int k = 0; k < n; k++) begin
            m.read_byte(k == n - 1, d, a);
            check(d, exp_mem[p]);
            if (p != ADDR_MAX) p = p + 10'h001;
        end
        check({7'h00, a}, 8'h01);
        m.stop_cond();
        repeat (4) @(posedge clk_sys);
        check({7'h00, sda_oe}, 8'h00);
    endtask : read_seq

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        int n;
        logic a;
        logic [7:0] d;
        sys_rst = 1'b1;
        device_select_input = 1'b0;
        bulk_erase_input = 1'b0;
        err_total = 0;
        check_count = 0;
        foreach (exp_mem[i]) exp_mem[i] = ERASED_BYTE;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check({5'h00, sda_o, sda_oe, prog_busy}, 8'h00);
        // Ordinary writes, each polled and read back
        foreach (rows[r]) begin
            prog(rows[r][18:9], rows[r][8:1], 1'b0);
            check({7'h00, prog_busy}, {7'h00, rows[r][0]});
            poll(n);
            check({7'h00, n != 0}, {7'h00, rows[r][0]});
            read_seq(rows[r][18:9], 1);
        end
        // Reading past the last word repeats it
        prog(10'h3FF, 8'h3C, 1'b0);
        poll(n);
        read_seq(10'h3FE, 3);
        // Write select in mid-programming aborts; a bare stop is inert
        prog(10'h155, 8'h00, 1'b0);
        m.start_cond();
        m.write_byte(sel(1'b0, 2'h1, 1'b0), a);
        check({7'h00, a}, 8'h00);
        check({7'h00, prog_busy}, 8'h00);
        m.stop_cond();
        repeat (20) @(posedge clk_sys);
        check({7'h00, prog_busy}, 8'h00);
        // Select bit against the strap pin
        @(posedge clk_sys);
        device_select_input <= 1'b1;
        m.start_cond();
        m.write_byte(sel(1'b0, 2'h0, 1'b1), a);
        check({7'h00, a}, 8'h01);
        m.stop_cond();
        m.start_cond();
        m.write_byte(sel(1'b1, 2'h0, 1'b1), a);
        check({7'h00, a}, 8'h00);
        m.read_byte(1'b1, d, a);
        m.stop_cond();
        @(posedge clk_sys);
        device_select_input <= 1'b0;
        // Whole-array erase armed by the pin at the stop
        prog(10'h000, ERASED_BYTE, 1'b1);
        check({7'h00, prog_busy}, 8'h01);
        poll(n);
        @(posedge clk_sys);
        bulk_erase_input <= 1'b0;
        foreach (exp_mem[i]) exp_mem[i] = ERASED_BYTE;
        read_seq(10'h1FF, 1);
        read_seq(10'h3FF, 1);
        // A fourth byte is refused and its stop launches nothing
        m.start_cond();
        m.write_byte(sel(1'b0, 2'h0, 1'b0), a);
        m.write_byte(8'h10, a);
        m.write_byte(8'h00, a);
        m.write_byte(8'h00, a);
        check({7'h00, a}, 8'h01);
        m.stop_cond();
        check({7'h00, prog_busy}, 8'h00);
        // Reset in mid-programming stops the cycle and frees the line
        prog(10'h010, 8'h00, 1'b0);
        check({7'h00, prog_busy}, 8'h01);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check({5'h00, sda_o, sda_oe, prog_busy}, 8'h00);
        foreach (exp_mem[i]) exp_mem[i] = ERASED_BYTE;
        read_seq(10'h010, 1);
        wrap_up();
    end

    // Hang guard, well beyond the expected run time
    initial begin
        #700_000;
        err_total++;
        wrap_up();
    end
endmodule : testbench
